// file: sdwb_ctrl.sv
// controller end: apb registers, link clock divider, write sequencing and recovery timing
`include "sdwb_defs.svh"
// Summary of operation
// - burst bits 10 force four-beat chop
// - bits 00, or 01 with chop high: eight
// - bits 01 with chop bit low: four
// - recovery counted from edge after last beat
// - no precharge before write recovery elapsed
// - inversion enabled selects inversion recovery time unless crc plus mask
// - crc plus mask select combined recovery, turnaround
// - two-cycle preamble needs latency above minimum
// - two-cycle preamble forbids six-clock write spacing
// - major timing violation demands full reset, initialization
// - minor violations never hang, error contained
// - strobe outside window is a major violation
// - precharge spacing latency plus burst plus recovery
module sdwb_ctrl (
  input  wire logic        CLOCK,
  input  wire logic        ARST_N,
  input  wire logic        CE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  sdwb_if.ctrl             LNK
);
  sdwb_pkg::sdwb_cstate_e st_r;
  logic [15:0] ctrl_r;
  logic [31:0] data_r;
  logic [23:0] twr_r;
  logic [31:0] wtr_r;
  logic [7:0]  ccd_r;
  logic        ph_r, go_bc_nxt, go_ap_nxt;
  logic        go_p_r, pre_p_r, mr_p_r, init_p_r, bc_r, apre_r, refused_r, need_init_r;
  logic [1:0]  bank_r, go_bank_nxt;
  logic [5:0]  lat_r;
  logic [2:0]  beats_r;
  logic        viol_s1_r, viol_s2_r;
  logic        ck_r, rst_n_r, wr_r, pre_r, mr_r, dqs_r;
  logic [15:0] dq_r;
  logic        twr_done, wtrs_done, wtrl_done, ccd_done, init_done;
  // link clock is CLOCK divided by two; link outputs change as it falls, except mr_val and the release of rst_n
  wire tick    = CE & ph_r;
  wire acc     = PSEL & PENABLE;
  wire wr_en   = acc & PWRITE;
  wire a_ctrl  = (PADDR == `SDWB_A_CTRL);
  wire a_cmd   = (PADDR == `SDWB_A_CMD);
  wire a_data  = (PADDR == `SDWB_A_DATA);
  wire a_twr   = (PADDR == `SDWB_A_TWR);
  wire a_wtr   = (PADDR == `SDWB_A_WTR);
  wire a_ccd   = (PADDR == `SDWB_A_CCD);
  wire a_stat  = (PADDR == `SDWB_A_STAT);
  wire mapped  = a_ctrl | a_cmd | a_data | a_twr | a_wtr | a_ccd | a_stat;
  wire cmd_wr  = wr_en & a_cmd;
  wire busy    = (st_r != sdwb_pkg::SDWB_C_IDLE);
  wire pre2    = ctrl_r[`SDWB_C_PRE2];
  wire crc_dm  = ctrl_r[`SDWB_C_CRC] & ctrl_r[`SDWB_C_DM];
  wire [4:0] column_write_latency = ctrl_r[`SDWB_C_CWL_LSB +: 5];
  wire [4:0] al  = ctrl_r[`SDWB_C_AL_LSB +: 5];
  wire [5:0] wl  = {1'b0, al} + {1'b0, column_write_latency};
  wire cfg_err = pre2 & (column_write_latency <= `SDWB_CWL_MIN);
  wire [7:0] ccd_eff = (pre2 && ccd_r == `SDWB_CCD_BAD) ? `SDWB_CCD_FIX : ccd_r;
  wire [7:0] twr_sel = crc_dm ? twr_r[23:16] :
                       ctrl_r[`SDWB_C_DBI] ? twr_r[15:8] : twr_r[7:0];
  wire [7:0] wtrs_sel = crc_dm ? wtr_r[23:16] : wtr_r[7:0];
  wire [7:0] wtrl_sel = crc_dm ? wtr_r[31:24] : wtr_r[15:8];
  wire [2:0] clocks  = sdwb_pkg::sdwb_burst_clocks(ctrl_r[1:0], bc_r);
  wire idle_like = (st_r == sdwb_pkg::SDWB_C_IDLE) | (st_r == sdwb_pkg::SDWB_C_REC);
  wire start_wr  = tick & idle_like & go_p_r & ccd_done & !cfg_err & !need_init_r & !init_p_r;
  wire refuse_wr = tick & idle_like & go_p_r & (cfg_err | need_init_r);
  wire start_init = tick & idle_like & init_p_r;
  wire start_mr  = tick & idle_like & mr_p_r & !go_p_r & !init_p_r;
  wire [7:0] pad = (ctrl_r[1:0] == sdwb_pkg::SDWB_PER_CMD && !bc_r) ? `SDWB_OTF_PAD : 8'h00;
  // the burst's end starts recovery on that same tick, as the link clock falls
  wire last_beat = tick & (st_r == sdwb_pkg::SDWB_C_DATA) & (beats_r == 3'h0);
  wire do_pre    = tick & idle_like & !start_wr & !start_init & twr_done &
                   (pre_p_r | (apre_r & st_r == sdwb_pkg::SDWB_C_REC));
  wire [31:0] stat = {21'h0, st_r, 1'b0, refused_r, need_init_r, cfg_err,
                      wtrl_done, wtrs_done, twr_done, busy};
  assign PREADY    = 1'b1;
  assign PSLVERR   = acc & !mapped;
  assign LNK.ck    = ck_r;
  assign LNK.rst_n = rst_n_r;
  assign LNK.cmd_wr  = wr_r;
  assign LNK.cmd_pre = pre_r;
  assign LNK.cmd_mr  = mr_r;
  assign LNK.bc_bit  = bc_r;
  assign LNK.bank    = bank_r;
  assign LNK.mr_val  = {wl[4:0], ctrl_r[1:0]};
  assign LNK.dqs     = dqs_r;
  assign LNK.dq      = dq_r;
  sdwb_cnt u_twr (.clk(CLOCK), .arst_n(ARST_N), .en(tick), .load(last_beat),
                  .val(twr_sel + pad), .done(twr_done));
  sdwb_cnt u_wtrs (.clk(CLOCK), .arst_n(ARST_N), .en(tick), .load(last_beat),
                   .val(wtrs_sel + pad), .done(wtrs_done));
  sdwb_cnt u_wtrl (.clk(CLOCK), .arst_n(ARST_N), .en(tick), .load(last_beat),
                   .val(wtrl_sel + pad), .done(wtrl_done));
  sdwb_cnt u_ccd (.clk(CLOCK), .arst_n(ARST_N), .en(tick), .load(start_wr),
                  .val(ccd_eff - 8'h01), .done(ccd_done));
  sdwb_cnt u_init (.clk(CLOCK), .arst_n(ARST_N), .en(tick), .load(start_init),
                   .val(`SDWB_INIT_TICKS), .done(init_done));
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ctrl_r <= `SDWB_CTRL_RST;
      data_r <= 32'h00000000;
      twr_r  <= `SDWB_TWR_RST;
      wtr_r  <= `SDWB_WTR_RST;
      ccd_r  <= `SDWB_CCD_RST;
      PRDATA <= 32'h00000000;
    end
    else if (CE)
    begin
      if (wr_en && a_ctrl)
        ctrl_r <= PWDATA[15:0];
      if (wr_en && a_data)
        data_r <= PWDATA;
      if (wr_en && a_twr)
        twr_r <= PWDATA[23:0];
      if (wr_en && a_wtr)
        wtr_r <= PWDATA;
      if (wr_en && a_ccd)
        ccd_r <= PWDATA[7:0];
      if (PSEL && !PENABLE && !PWRITE)
        PRDATA <= a_ctrl ? {16'h0000, ctrl_r} : a_data ? data_r :
                  a_twr ? {8'h00, twr_r} : a_wtr ? wtr_r :
                  a_ccd ? {24'h000000, ccd_r} : a_stat ? stat : 32'h00000000;
    end
  end
  // pending orders; a new order overrides, consumption clears
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      go_p_r <= 1'b0;
      pre_p_r <= 1'b0;
      mr_p_r <= 1'b0;
      init_p_r <= 1'b0;
      refused_r <= 1'b0;
      need_init_r <= 1'b0;
      viol_s1_r <= 1'b0;
      viol_s2_r <= 1'b0;
      go_bc_nxt <= 1'b1;
      go_ap_nxt <= 1'b0;
      go_bank_nxt <= 2'h0;
    end
    else if (CE)
    begin
      viol_s1_r <= LNK.viol_major;
      viol_s2_r <= viol_s1_r;
      if (cmd_wr && PWDATA[`SDWB_K_GO])
      begin
        go_p_r <= 1'b1;
        go_bc_nxt <= PWDATA[`SDWB_K_BC];
        go_ap_nxt <= PWDATA[`SDWB_K_AUTOPRE];
        go_bank_nxt <= PWDATA[`SDWB_K_BANK_LSB +: 2];
      end
      else if (start_wr || refuse_wr)
        go_p_r <= 1'b0;
      if (cmd_wr && PWDATA[`SDWB_K_PRE])
        pre_p_r <= 1'b1;
      else if (do_pre)
        pre_p_r <= 1'b0;
      if (cmd_wr && PWDATA[`SDWB_K_MR])
        mr_p_r <= 1'b1;
      else if (start_mr)
        mr_p_r <= 1'b0;
      if (cmd_wr && PWDATA[`SDWB_K_INIT])
        init_p_r <= 1'b1;
      else if (start_init)
        init_p_r <= 1'b0;
      if (refuse_wr)
        refused_r <= 1'b1;
      else if (start_wr)
        refused_r <= 1'b0;
      // a violation seen during reinit still wins
      if (viol_s2_r)
        need_init_r <= 1'b1;
      else if (st_r == sdwb_pkg::SDWB_C_INIT && tick && init_done)
        need_init_r <= 1'b0;
    end
  end
  // link sequencer, one step per link clock
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      st_r <= sdwb_pkg::SDWB_C_IDLE;
      ph_r <= 1'b0;
      ck_r <= 1'b0;
      rst_n_r <= 1'b0;
      wr_r <= 1'b0;
      pre_r <= 1'b0;
      mr_r <= 1'b0;
      dqs_r <= 1'b0;
      dq_r <= 16'h0000;
      bc_r <= 1'b0;
      apre_r <= 1'b0;
      bank_r <= 2'h0;
      lat_r <= 6'h00;
      beats_r <= 3'h0;
    end
    else if (CE)
    begin
      ph_r <= ~ph_r;
      ck_r <= ~ph_r;
      if (!init_p_r && !start_init && st_r == sdwb_pkg::SDWB_C_IDLE)
        rst_n_r <= 1'b1;
      if (tick)
      begin
        wr_r <= start_wr;
        pre_r <= do_pre;
        mr_r <= start_mr;
        if (start_init)
        begin
          rst_n_r <= 1'b0;
          st_r <= sdwb_pkg::SDWB_C_INIT;
        end
        else if (start_wr)
        begin
          lat_r <= wl;
          st_r <= sdwb_pkg::SDWB_C_LAT;
          bc_r <= go_bc_nxt;
          apre_r <= go_ap_nxt;
          bank_r <= go_bank_nxt;
        end
        else
        begin
          case (st_r)
            sdwb_pkg::SDWB_C_LAT:
            begin
              if (lat_r <= 6'h01)
              begin
                dqs_r <= 1'b1;
                dq_r <= data_r[15:0];
                beats_r <= clocks - 3'h1;
                st_r <= sdwb_pkg::SDWB_C_DATA;
              end
              else
                lat_r <= lat_r - 6'h01;
            end
            sdwb_pkg::SDWB_C_DATA:
            begin
              if (beats_r == 3'h0)
              begin
                dqs_r <= 1'b0;
                st_r <= sdwb_pkg::SDWB_C_REC;
              end
              else
              begin
                dq_r <= data_r[15:0] ^ {13'h0, beats_r};
                beats_r <= beats_r - 3'h1;
              end
            end
            sdwb_pkg::SDWB_C_REC:
              if (twr_done && (!apre_r || do_pre))
                st_r <= sdwb_pkg::SDWB_C_IDLE;
            sdwb_pkg::SDWB_C_INIT:
              if (init_done)
                st_r <= sdwb_pkg::SDWB_C_IDLE;
            default:
              st_r <= sdwb_pkg::SDWB_C_IDLE;
          endcase
        end
      end
    end
  end
endmodule

// file: sdwb_defs.svh
// constants for the write burst link: offsets, fields, reset values, counts
`ifndef SDWB_DEFS_SVH
`define SDWB_DEFS_SVH
`define SDWB_A_CTRL      8'h00
`define SDWB_A_CMD       8'h04
`define SDWB_A_DATA      8'h08
`define SDWB_A_TWR       8'h0C
`define SDWB_A_WTR       8'h10
`define SDWB_A_CCD       8'h14
`define SDWB_A_STAT      8'h18
`define SDWB_C_DBI       2
`define SDWB_C_CRC       3
`define SDWB_C_DM        4
`define SDWB_C_PRE2      5
`define SDWB_C_CWL_LSB   6
`define SDWB_C_AL_LSB    11
`define SDWB_K_GO        0
`define SDWB_K_BC        1
`define SDWB_K_AUTOPRE   2
`define SDWB_K_PRE       3
`define SDWB_K_MR        4
`define SDWB_K_INIT      5
`define SDWB_K_BANK_LSB  8
`define SDWB_CTRL_RST    16'h0240
`define SDWB_TWR_RST     24'h0C0C0C
`define SDWB_WTR_RST     32'h04040404
`define SDWB_CCD_RST     8'h04
`define SDWB_CWL_MIN     5'h09
`define SDWB_CCD_BAD     8'h06
`define SDWB_CCD_FIX     8'h07
`define SDWB_CLK_BL8     3'h4
`define SDWB_CLK_BC4     3'h2
`define SDWB_OTF_PAD     8'h02
`define SDWB_SLIP        3'h2
`define SDWB_INIT_TICKS  8'h10
`endif

// file: sdwb_pkg.sv
// types and shared burst decode for the write burst link
package sdwb_pkg;
`include "sdwb_defs.svh"
  typedef enum logic [1:0] {
    SDWB_BL8_FIXED = 2'h0,
    SDWB_PER_CMD   = 2'h1,
    SDWB_BC4_FIXED = 2'h2
  } sdwb_burst_e;

  typedef enum logic [2:0] {
    SDWB_C_IDLE = 3'h0,
    SDWB_C_LAT  = 3'h1,
    SDWB_C_DATA = 3'h3,
    SDWB_C_REC  = 3'h2,
    SDWB_C_INIT = 3'h6
  } sdwb_cstate_e;

  typedef enum logic [1:0] {
    SDWB_D_IDLE = 2'h0,
    SDWB_D_LAT  = 2'h1,
    SDWB_D_DATA = 2'h3
  } sdwb_dstate_e;

  // clocks of data per burst; two beats per clock
  function automatic logic [2:0] sdwb_burst_clocks(input logic [1:0] ctl, input logic bc);
    logic [2:0] c;
    c = `SDWB_CLK_BL8;
    if (ctl == SDWB_BC4_FIXED)
      c = `SDWB_CLK_BC4;
    else if (ctl == SDWB_PER_CMD && !bc)
      c = `SDWB_CLK_BC4;
    else
      c = `SDWB_CLK_BL8;
    return c;
  endfunction
endpackage

// file: sdwb_if.sv
// link between the controller end and the memory device end
interface sdwb_if;
  logic        ck;
  logic        rst_n;
  logic        cmd_wr;
  logic        cmd_pre;
  logic        cmd_mr;
  logic        bc_bit;
  logic [1:0]  bank;
  logic [6:0]  mr_val;
  logic        dqs;
  logic [15:0] dq;
  logic        viol_major;
  modport ctrl (output ck, rst_n, cmd_wr, cmd_pre, cmd_mr, bc_bit, bank, mr_val, dqs, dq,
                input viol_major);
  modport dev  (input ck, rst_n, cmd_wr, cmd_pre, cmd_mr, bc_bit, bank, mr_val, dqs, dq,
                output viol_major);
endinterface

// file: sdwb_cnt.sv
// loadable down counter advancing on link ticks
module sdwb_cnt (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       en,
  input  wire logic       load,
  input  wire logic [7:0] val,
  output logic            done
);
  logic [7:0] cnt_r;

  assign done = (cnt_r == 8'h00);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_r <= 8'h00;
    else if (load)
      cnt_r <= val;
    else if (en && !done)
      cnt_r <= cnt_r - 8'h01;
  end
endmodule

// file: sdwb_dev.sv
// memory device end: burst decode, latency wait and write data capture
`include "sdwb_defs.svh"
module sdwb_dev (
  input  wire logic        ARST_N,
  input  wire logic        CE,
  output logic [15:0]      WDATA,
  output logic             WVALID,
  output logic             WLAST,
  output logic [1:0]       WBANK,
  output logic             CHOPPED,
  output logic             MINOR,
  output logic             MAJOR,
  sdwb_if.dev              LNK
);
  sdwb_pkg::sdwb_dstate_e st_r;
  logic [6:0] mr_r;
  logic [5:0] lat_r;
  logic [2:0] beats_r;
  logic [2:0] slip_r;
  wire        rst_c = ARST_N & LNK.rst_n;
  wire [2:0]  clocks = sdwb_pkg::sdwb_burst_clocks(mr_r[1:0], LNK.bc_bit);
  wire [5:0]  wl = {1'b0, mr_r[6:2]};
  wire        late_out = (slip_r == `SDWB_SLIP);

  assign LNK.viol_major = MAJOR;

  always_ff @(posedge LNK.ck or negedge rst_c)
  begin
    if (!rst_c)
    begin
      st_r    <= sdwb_pkg::SDWB_D_IDLE;
      mr_r    <= 7'h24;
      lat_r   <= 6'h00;
      beats_r <= 3'h0;
      slip_r  <= 3'h0;
      WDATA   <= 16'h0000;
      WVALID  <= 1'b0;
      WLAST   <= 1'b0;
      WBANK   <= 2'h0;
      CHOPPED <= 1'b0;
      MINOR   <= 1'b0;
      MAJOR   <= 1'b0;
    end
    else if (CE)
    begin
      WVALID <= 1'b0;
      WLAST  <= 1'b0;
      MINOR  <= 1'b0;
      case (st_r)
        sdwb_pkg::SDWB_D_IDLE:
        begin
          if (LNK.cmd_mr)
            mr_r <= LNK.mr_val;
          else if (LNK.cmd_wr)
          begin
            beats_r <= clocks;
            CHOPPED <= (clocks == `SDWB_CLK_BC4);
            WBANK   <= LNK.bank;
            lat_r   <= wl - 6'h01;
            slip_r  <= 3'h0;
            st_r    <= sdwb_pkg::SDWB_D_LAT;
          end
        end
        sdwb_pkg::SDWB_D_LAT:
        begin
          if (lat_r <= 6'h01)
            st_r <= sdwb_pkg::SDWB_D_DATA;
          else
            lat_r <= lat_r - 6'h01;
        end
        sdwb_pkg::SDWB_D_DATA:
        begin
          if (LNK.dqs)
          begin
            WDATA   <= LNK.dq;
            WVALID  <= 1'b1;
            WLAST   <= (beats_r == 3'h1);
            beats_r <= beats_r - 3'h1;
            if (beats_r == 3'h1)
              st_r <= sdwb_pkg::SDWB_D_IDLE;
          end
          else if (late_out)
          begin
            // strobe never arrived in its window: flag and abandon only this burst
            MAJOR <= 1'b1;
            st_r  <= sdwb_pkg::SDWB_D_IDLE;
          end
          else
          begin
            slip_r <= slip_r + 3'h1;
            MINOR  <= 1'b1;
          end
        end
        default:
          st_r <= sdwb_pkg::SDWB_D_IDLE;
      endcase
    end
  end
endmodule

// file: sdwb_asserts.sv
// link-side protocol checker for the write burst link
module sdwb_asserts #(
  parameter int MIN_TWR = 12
) (
  input wire logic        ck,
  input wire logic        rst_n,
  input wire logic        cmd_wr,
  input wire logic        cmd_pre,
  input wire logic        cmd_mr,
  input wire logic        bc_bit,
  input wire logic [1:0]  bank,
  input wire logic [6:0]  mr_val,
  input wire logic        dqs,
  input wire logic [15:0] dq,
  input wire logic        viol_major
);
  logic [4:0] wl_r;
  logic [1:0] bm_r;
  logic       bc_r;
  logic [6:0] wc_r;
  logic [2:0] run_r;
  // burst size worked out here, not through the shared package decode
  wire  [2:0] need = (bm_r == 2'h2 || (bm_r == 2'h1 && !bc_r)) ? 3'h2 : 3'h4;
  // precharge spacing keeps the four-clock slot unless the chop is fixed
  wire  [2:0] slot = (bm_r == 2'h2) ? 3'h2 : 3'h4;

  always_ff @(posedge ck or negedge rst_n)
    if (!rst_n)
    begin
      wl_r  <= 5'h09;
      bm_r  <= 2'h0;
      bc_r  <= 1'b1;
      wc_r  <= 7'h7F;
      run_r <= 3'h0;
    end
    else
    begin
      if (cmd_mr)
      begin
        wl_r <= mr_val[6:2];
        bm_r <= mr_val[1:0];
      end
      if (cmd_wr)
        bc_r <= bc_bit;
      // saturates so a long idle never wraps into a false spacing
      wc_r  <= cmd_wr ? 7'h01 : (wc_r == 7'h7F ? wc_r : wc_r + 7'h01);
      run_r <= dqs ? run_r + 3'h1 : 3'h0;
    end

  default clocking cb @(posedge ck); endclocking
  default disable iff (!rst_n);

  lat_pos_a: assert property ($rose(dqs) |-> wc_r == {2'h0, wl_r})
    else $error("strobe off the latency position");
  chop_fixed_a: assert property ($fell(dqs) && bm_r == 2'h2 |-> run_r == 3'h2)
    else $error("fixed chop burst length wrong");
  eight_sel_a: assert property ($fell(dqs) && need == 3'h4 |-> run_r == 3'h4)
    else $error("eight beat burst length wrong");
  chop_cmd_a: assert property ($fell(dqs) && bm_r == 2'h1 && !bc_r |-> run_r == 3'h2)
    else $error("per command chop length wrong");
  pre_space_a: assert property (cmd_pre |-> int'(wc_r) >= int'(wl_r) + int'(slot) + MIN_TWR)
    else $error("precharge too close to write");
  pre_idle_a: assert property (cmd_pre |-> !dqs && !cmd_wr && !$past(dqs))
    else $error("precharge during write data");
  wr_gap_a: assert property (cmd_wr |-> int'(wc_r) >= int'(wl_r) + int'(need))
    else $error("write issued inside previous burst");
  no_major_a: assert property (cmd_wr |=> !viol_major [*8])
    else $error("violation on a clean link");
  mode_ok_a: assert property (cmd_mr |-> mr_val[1:0] != 2'h3 && mr_val[6:2] >= 5'h02)
    else $error("illegal mode value loaded");
endmodule

// file: sdram_write_burst_timing_tb.sv
// self-checking bench for both ends of the write burst link
`include "sdwb_defs.svh"
module sdram_write_burst_timing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        er;
  logic        ck2_en = 1'b0;
  logic        wvd = 1'b0;
  logic        dqs_d = 1'b0;
  logic [15:0] wdata;
  logic [15:0] first;
  logic        wvalid;
  logic        chopped;
  logic        wv2;
  logic        minor2;
  logic        major2;
  logic [1:0]  wbank;
  int          bad_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          nv = 0;
  int          nv2 = 0;
  int          mn = 0;
  int          pre_n = 0;
  int          gcnt = 0;
  int          gap = 0;
  int          k0 = 0;
  int          v;
  int          p;
  // [15:0] control, [16] chop bit, [19:17] data clocks, [20] chopped, [31:24] recovery
  logic [31:0] rows [8] = '{32'h0C080240, 32'h0C090241, 32'h0E140241, 32'h0C150242,
                            32'h0F090244, 32'h14090258, 32'h0F09024C, 32'h0C140252};
  logic [7:0]  ra [5] = '{`SDWB_A_CTRL, `SDWB_A_TWR, `SDWB_A_WTR, `SDWB_A_CCD, `SDWB_A_CMD};
  logic [31:0] rv [5] = '{32'h0240, 32'h0C0C0C, 32'h04040404, 32'h4, 32'h0};

  sdwb_if lnk ();
  sdwb_if lk2 ();
  sdwb_ctrl sdwb_ctrl_inst (.CLOCK(clock), .ARST_N(arst_n), .CE(1'b1), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .LNK(lnk));
  sdwb_dev sdwb_dev_inst (.ARST_N(arst_n), .CE(1'b1), .WDATA(wdata), .WVALID(wvalid),
    .WLAST(), .WBANK(wbank), .CHOPPED(chopped), .MINOR(), .MAJOR(), .LNK(lnk));
  // second device faced by the bench itself, so faults can be injected
  if (1)
  begin : fault_side
    sdwb_dev sdwb_dev_inst (.ARST_N(arst_n), .CE(1'b1), .WDATA(), .WVALID(wv2), .WLAST(),
      .WBANK(), .CHOPPED(), .MINOR(minor2), .MAJOR(major2), .LNK(lk2));
  end
  sdwb_asserts #(.MIN_TWR(12)) sdwb_asserts_inst (.ck(lnk.ck), .rst_n(lnk.rst_n),
    .cmd_wr(lnk.cmd_wr), .cmd_pre(lnk.cmd_pre), .cmd_mr(lnk.cmd_mr), .bc_bit(lnk.bc_bit),
    .bank(lnk.bank), .mr_val(lnk.mr_val), .dqs(lnk.dqs), .dq(lnk.dq),
    .viol_major(lnk.viol_major));

  always #25 clock = ~clock;
  // fault link clock only runs inside frames
  always #6 lk2.ck = ck2_en ? ~lk2.ck : 1'b0;

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      bad_count++;
      complete_run();
    end
  end

  always @(posedge lnk.ck)
  begin
    wvd <= wvalid;
    if (wvalid)
      nv <= nv + 1;
    if (wvalid && !wvd)
      first <= wdata;
    dqs_d <= lnk.dqs;
    gcnt <= (dqs_d && !lnk.dqs) ? 1 : gcnt + 1;
    if (lnk.cmd_pre)
    begin
      gap <= gcnt;
      pre_n <= pre_n + 1;
    end
  end

  always @(posedge lk2.ck)
  begin
    if (wv2)
      nv2 <= nv2 + 1;
    if (minor2)
      mn <= mn + 1;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // polls until idle and, when p0 is not negative, until a precharge was seen
  task automatic wait_idle(input int p0);
    // let a just-written order reach the sequencer before busy is trusted
    repeat (2) @(posedge clock);
    do
      apb(1'b0, `SDWB_A_STAT, 32'h0);
    while (rd[0] !== 1'b0 || (p0 >= 0 && pre_n == p0));
  endtask

  task automatic fault(input int late);
    @(posedge lk2.ck);
    lk2.cmd_wr <= 1'b1;
    @(posedge lk2.ck);
    lk2.cmd_wr <= 1'b0;
    repeat (8 + late) @(posedge lk2.ck);
    lk2.dqs <= 1'b1;
    lk2.dq <= 16'h5AC3;
    repeat (4) @(posedge lk2.ck);
    lk2.dqs <= 1'b0;
    lk2.dq <= 16'hA53C;
    repeat (14) @(posedge lk2.ck);
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    {lk2.rst_n, lk2.cmd_wr, lk2.cmd_pre, lk2.cmd_mr, lk2.dqs} = 5'h0;
    {lk2.bc_bit, lk2.bank, lk2.mr_val, lk2.dq} = 26'h0;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset value", rv[i], rd);
    end
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, `SDWB_A_TWR, 32'h00140F0C);
    for (int i = 0; i < 8; i++)
    begin
      p = pre_n;
      v = nv;
      apb(1'b1, `SDWB_A_CTRL, {16'h0, rows[i][15:0]});
      apb(1'b1, `SDWB_A_CMD, 32'h10);
      wait_idle(-1);
      apb(1'b1, `SDWB_A_DATA, 32'hA000 + i);
      apb(1'b1, `SDWB_A_CMD, 32'h5 | {rows[i][16], 1'b0} | ((i % 4) << 8));
      wait_idle(p);
      chk("data clocks", rows[i][19:17], nv - v);
      chk("first pair", 32'hA000 + i, first);
      chk("chopped", rows[i][20], chopped);
      chk("bank", i % 4, wbank);
      if (i == 0)
        k0 = gap - 32'hC;
      chk("recovery", rows[i][31:24] + k0, gap);
    end
    chk("recovery origin", 32'h1, k0 >= 0 && k0 <= 2);
    apb(1'b1, `SDWB_A_CTRL, 32'h0260);
    v = nv;
    apb(1'b1, `SDWB_A_CMD, 32'h1);
    wait_idle(-1);
    chk("latency too low", 32'h1, rd[4]);
    chk("write refused", 32'h1, rd[6]);
    chk("no data", v, nv);
    apb(1'b1, `SDWB_A_CTRL, 32'h0AA0);
    apb(1'b1, `SDWB_A_CMD, 32'h10);
    wait_idle(-1);
    chk("latency accepted", 32'h0, rd[4]);
    apb(1'b1, `SDWB_A_CMD, 32'h3);
    wait_idle(-1);
    chk("long preamble burst", 32'h4, nv - v);
    ck2_en = 1'b1;
    @(posedge lk2.ck);
    lk2.rst_n <= 1'b1;
    v = nv2;
    fault(1);
    chk("late strobe flagged", 32'h1, mn > 0);
    chk("late strobe no hang", 32'h0, major2);
    fault(0);
    chk("next write intact", v + 8, nv2);
    fault(9);
    chk("strobe outside window", 32'h1, major2);
    chk("violation on link", 32'h1, lk2.viol_major);
    ck2_en = 1'b0;
    apb(1'b1, `SDWB_A_CMD, 32'h20);
    repeat (2) @(posedge clock);
    apb(1'b0, `SDWB_A_STAT, 32'h0);
    chk("init running", 32'h6, rd[10:8]);
    wait_idle(-1);
    apb(1'b1, `SDWB_A_CTRL, 32'h0241);
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    apb(1'b0, `SDWB_A_CTRL, 32'h0);
    chk("ctrl after reset", 32'h0240, rd);
    chk("violation cleared", 32'h0, major2);
    complete_run();
  end
endmodule
